/* File: lsm_pkg.sv */
/*
  Shared constants and carrier types of the lock and signal alarm monitor.
  Assumes a classic Wishbone master with 32-bit data and byte addresses.
*/
package lsm_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] OFS_CHIP_CFG    = 8'h02;
  localparam logic [7:0] OFS_RX_IRQ      = 8'h05;
  localparam logic [7:0] OFS_RX_LOCK_CFG = 8'h07;
  localparam logic [7:0] OFS_RX_CAL_CFG  = 8'h08;
  localparam logic [7:0] OFS_RX_ALARM    = 8'h09;
  localparam logic [7:0] OFS_RX_PATH_CFG = 8'h1c;
  localparam logic [7:0] OFS_TUNE_B      = 8'h43;
  localparam logic [7:0] OFS_TUNE_C      = 8'h44;
  localparam logic [7:0] OFS_DET_GAIN    = 8'h4d;
  localparam logic [7:0] OFS_TUNE_A      = 8'h56;
  localparam logic [7:0] OFS_ACQ_LOOP    = 8'h62;
  localparam logic [7:0] OFS_JT_INDEX    = 8'h6a;
  localparam logic [7:0] OFS_JT_DATA0    = 8'h6b;
  localparam logic [7:0] OFS_JT_DATA1    = 8'h6c;
  localparam logic [7:0] OFS_JT_DATA2    = 8'h6d;
  localparam logic [7:0] OFS_TX_IRQ      = 8'h85;
  localparam logic [7:0] OFS_TX_LOCK_CFG = 8'h87;
  localparam logic [7:0] OFS_TX_CAL_CFG  = 8'h88;
  localparam logic [7:0] OFS_TX_LOS_CTRL = 8'h8a;
  localparam logic [7:0] OFS_TX_LOS_FLAG = 8'h8b;
  localparam logic [7:0] OFS_RUN_ASSERT  = 8'h91;
  localparam logic [7:0] OFS_RUN_CLEAR   = 8'h92;
  localparam logic [7:0] OFS_EYE_VALUE   = 8'h99;
  localparam logic [7:0] OFS_EYE_CFG     = 8'h9a;
  localparam logic [7:0] OFS_EYE_RELEASE = 8'h9b;
  localparam logic [7:0] OFS_TX_PATH_CFG = 8'h9c;
  localparam logic [7:0] OFS_EYE_THRESH  = 8'ha0;

  // storage slots of the writable registers
  localparam logic [4:0] S_CHIP_CFG    = 5'h00;
  localparam logic [4:0] S_RX_LOCK_CFG = 5'h01;
  localparam logic [4:0] S_RX_CAL_CFG  = 5'h02;
  localparam logic [4:0] S_RX_PATH_CFG = 5'h03;
  localparam logic [4:0] S_TUNE_B      = 5'h04;
  localparam logic [4:0] S_TUNE_C      = 5'h05;
  localparam logic [4:0] S_DET_GAIN    = 5'h06;
  localparam logic [4:0] S_TUNE_A      = 5'h07;
  localparam logic [4:0] S_ACQ_LOOP    = 5'h08;
  localparam logic [4:0] S_JT_INDEX    = 5'h09;
  localparam logic [4:0] S_JT_DATA0    = 5'h0a;
  localparam logic [4:0] S_JT_DATA1    = 5'h0b;
  localparam logic [4:0] S_JT_DATA2    = 5'h0c;
  localparam logic [4:0] S_TX_LOCK_CFG = 5'h0d;
  localparam logic [4:0] S_TX_CAL_CFG  = 5'h0e;
  localparam logic [4:0] S_TX_LOS_CTRL = 5'h0f;
  localparam logic [4:0] S_RUN_ASSERT  = 5'h10;
  localparam logic [4:0] S_RUN_CLEAR   = 5'h11;
  localparam logic [4:0] S_EYE_CFG     = 5'h12;
  localparam logic [4:0] S_EYE_RELEASE = 5'h13;
  localparam logic [4:0] S_TX_PATH_CFG = 5'h14;
  localparam logic [4:0] S_EYE_THRESH  = 5'h15;
  localparam int unsigned S_COUNT      = 22;

  localparam logic [7:0] BYTE_RESET = 8'h00;

  // field positions
  localparam int unsigned B_REF_RATIO  = 0;  // chip config: 1 selects /16
  localparam int unsigned B_RX_REF_EN  = 0;
  localparam int unsigned B_FORCE_LTR  = 1;
  localparam int unsigned B_MODE_LO    = 2;
  localparam int unsigned B_MODE_SEL   = 3;
  localparam int unsigned B_LTR_ON_LOS = 5;
  localparam int unsigned B_LOL_ON_LOS = 6;
  localparam int unsigned B_CAL_MODE   = 1;  // cal field [2:1], bit 1 low = reference
  localparam int unsigned B_SQ_ON_LOL  = 0;
  localparam int unsigned B_TX_SQUELCH = 0;
  localparam int unsigned B_TX_CLKPAT  = 1;
  localparam int unsigned B_RUN_EN     = 0;
  localparam int unsigned B_EYE_SEL    = 1;
  localparam int unsigned B_EYE_EN     = 0;
  localparam int unsigned B_JT_COMMIT  = 7;
  localparam logic [6:0]  JT_ADDR      = 7'h04;

  // frequency comparison limits in ppm
  localparam logic [15:0] FREQ_SET_PPM = 16'h03e8;
  localparam logic [15:0] FREQ_CLR_PPM = 16'h00c8;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lsm_wb_req_t;

  typedef struct packed {
    logic       prev;
    logic [7:0] run;
    logic [7:0] act;
    logic       alarm;
  } lsm_run_t;

  typedef struct packed {
    logic                     ack;
    logic [7:0]               rdata;
    logic [S_COUNT-1:0][7:0]  regs;
    logic [23:0]              jt_thresh;
    logic [2:0]               td_sync;
    logic                     td_bit;
    logic                     jit_lol;
    logic                     freq_lol;
    logic                     rx_lol;
    logic                     rx_irq;
    logic                     eye_alarm;
    logic                     tx_los;
    logic                     tx_irq;
    logic                     acq_search;
    logic                     rx_squelch;
    logic                     rx_ltr;
    logic                     tx_squelch;
    logic                     tx_clkpat;
    logic                     tx_ltr;
    logic                     tx_ref_cal;
  } lsm_state_t;

endpackage : lsm_pkg

/* File: lsm_run_length.sv */
/*
  Run-length signal loss detector for the synchronised transmit data bit.
  Assumes one sample per clock and thresholds held stable by software.
*/
module lsm_run_length (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       bit_in,
  input  wire logic [7:0] assert_thresh,
  input  wire logic [7:0] clear_thresh,
  output logic            alarm_q
);
  import lsm_pkg::*;

  localparam lsm_run_t RUN_RESET = '0;
  localparam logic [7:0] CNT_MAX = 8'hff;

  lsm_run_t q;
  lsm_run_t d;

  always_comb begin
    d = q;
    d.prev = bit_in;
    // counters saturate so a stuck line never wraps back to quiet
    if (bit_in != q.prev) begin
      d.run = BYTE_RESET;
    end else if (q.run != CNT_MAX) begin
      d.run = q.run + 8'h01;
    end
    if (d.run > assert_thresh) begin
      d.act = BYTE_RESET;
    end else if (q.act != CNT_MAX) begin
      d.act = q.act + 8'h01;
    end
    if (d.run > assert_thresh) begin
      d.alarm = 1'b1;                                   // RULE19
    end else if (q.alarm && (d.act > clear_thresh)) begin
      d.alarm = 1'b0;                                   // RULE19
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= RUN_RESET;
    end else begin
      q <= d;
    end
  end

  assign alarm_q = q.alarm;

endmodule : lsm_run_length

/* File: lsm_monitor.sv */
/*
  Loss-of-lock and loss-of-signal supervisor with its Wishbone register file.
  Assumes the analog monitors deliver their measures on this clock; only
  the transmit data pin is asynchronous and is synchronised here.
*/
// Summary of operation
// RULE1 - default mode picks detector from lock bit
// RULE2 - jitter detector on 11b or bit3=0,bit1=0
// RULE3 - frequency detector on 10b or bit3=0,bit1=1
// RULE4 - jitter above threshold sets lock lost
// RULE5 - lock lost restarts acquisition search
// RULE6 - threshold loaded through index and data registers
// RULE7 - host writes fixed threshold sequence
// RULE8 - frequency error over 1000 ppm sets, 200 clears
// RULE9 - chip config picks /64 or /16 reference
// RULE10 - host rewrites acquisition loop on lock changes
// RULE11 - dynamic writes optional with reference calibration
// RULE12 - host writes detector gain once
// RULE13 - host writes three tuning registers for speed
// RULE14 - lock lost in alarm and interrupt flags
// RULE15 - signal loss may force lock lost
// RULE16 - receive data squelched on lock lost
// RULE17 - force or on-loss bit locks to reference
// RULE18 - transmit loss combines enabled monitors
// RULE19 - run length alarm with clear threshold
// RULE20 - eye opening alarm with release hysteresis
// RULE21 - transmit loss squelches or sends clock
// RULE22 - transmit calibration mode and lock on loss
// RULE23 - force bit 1, on-loss bit 5
// RULE24 - config bit ties signal loss to lock
// RULE25 - frequency lock holds between limits
// RULE26 - alarm flags live, interrupt flags sticky
module lsm_monitor #(
  parameter logic [23:0] JT_DEFAULT = 24'h800000
) (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire lsm_pkg::lsm_wb_req_t wb_req,
  output logic                      wb_ack_q,
  output logic [31:0]               wb_dat_q,
  input  wire logic [23:0]          jitter_measure,
  input  wire logic [15:0]          freq_err_div64_ppm,
  input  wire logic [15:0]          freq_err_div16_ppm,
  input  wire logic                 receive_signal_loss,
  input  wire logic                 transmit_data_input,
  input  wire logic [7:0]           tx_eye_measure,
  output logic                      receive_lock_lost_q,
  output logic                      rx_acq_search_q,
  output logic                      rx_data_squelch_q,
  output logic                      rx_cmu_ref_lock_q,
  output logic                      tx_signal_loss_q,
  output logic                      tx_data_squelch_q,
  output logic                      tx_clock_pattern_q,
  output logic                      tx_lock_to_ref_q,
  output logic                      tx_ref_cal_q
);
  import lsm_pkg::*;

  // map a register index onto a storage slot
  function automatic logic [5:0] slot_of(input logic [7:0] idx);
    case (idx)
      OFS_CHIP_CFG:    slot_of = {1'b1, S_CHIP_CFG};
      OFS_RX_LOCK_CFG: slot_of = {1'b1, S_RX_LOCK_CFG};
      OFS_RX_CAL_CFG:  slot_of = {1'b1, S_RX_CAL_CFG};
      OFS_RX_PATH_CFG: slot_of = {1'b1, S_RX_PATH_CFG};
      OFS_TUNE_B:      slot_of = {1'b1, S_TUNE_B};
      OFS_TUNE_C:      slot_of = {1'b1, S_TUNE_C};
      OFS_DET_GAIN:    slot_of = {1'b1, S_DET_GAIN};
      OFS_TUNE_A:      slot_of = {1'b1, S_TUNE_A};
      OFS_ACQ_LOOP:    slot_of = {1'b1, S_ACQ_LOOP};
      OFS_JT_INDEX:    slot_of = {1'b1, S_JT_INDEX};
      OFS_JT_DATA0:    slot_of = {1'b1, S_JT_DATA0};
      OFS_JT_DATA1:    slot_of = {1'b1, S_JT_DATA1};
      OFS_JT_DATA2:    slot_of = {1'b1, S_JT_DATA2};
      OFS_TX_LOCK_CFG: slot_of = {1'b1, S_TX_LOCK_CFG};
      OFS_TX_CAL_CFG:  slot_of = {1'b1, S_TX_CAL_CFG};
      OFS_TX_LOS_CTRL: slot_of = {1'b1, S_TX_LOS_CTRL};
      OFS_RUN_ASSERT:  slot_of = {1'b1, S_RUN_ASSERT};
      OFS_RUN_CLEAR:   slot_of = {1'b1, S_RUN_CLEAR};
      OFS_EYE_CFG:     slot_of = {1'b1, S_EYE_CFG};
      OFS_EYE_RELEASE: slot_of = {1'b1, S_EYE_RELEASE};
      OFS_TX_PATH_CFG: slot_of = {1'b1, S_TX_PATH_CFG};
      OFS_EYE_THRESH:  slot_of = {1'b1, S_EYE_THRESH};
      default:         slot_of = 6'h00;
    endcase
  endfunction : slot_of

  // jitter detector unless the selection bits ask for frequency
  function automatic logic jitter_mode(input logic [7:0] cfg);
    jitter_mode = (cfg[B_MODE_SEL] && cfg[B_MODE_LO]) ||
                  (!cfg[B_MODE_SEL] && !cfg[B_FORCE_LTR]);
  endfunction : jitter_mode

  localparam lsm_state_t ST_RESET = '{
    ack:        1'b0,
    rdata:      BYTE_RESET,
    regs:       '0,
    jt_thresh:  JT_DEFAULT,
    td_sync:    3'h0,
    default:    1'b0
  };

  logic [1:0] rst_sync_q;
  logic       rst_n;
  lsm_state_t q;
  lsm_state_t d;
  logic       run_alarm;
  logic       req;
  logic [7:0] idx;
  logic [5:0] hit;
  logic       wr;
  logic       rd;
  logic [7:0] wbyte;
  logic [7:0] rx_cfg;
  logic [15:0] freq_err;
  logic [7:0] rx_alarm_byte;
  logic [7:0] tx_flag_byte;

  // reset is taken asynchronously but released on the clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  lsm_run_length u_run (
    .clock         (clock),
    .rst_n         (rst_n),
    .bit_in        (q.td_bit),
    .assert_thresh (q.regs[S_RUN_ASSERT]),
    .clear_thresh  (q.regs[S_RUN_CLEAR]),
    .alarm_q       (run_alarm)
  );

  assign req      = wb_req.cyc && wb_req.stb && !q.ack;
  assign idx      = wb_req.adr[9:2];
  assign hit      = slot_of(idx);
  assign wr       = req && wb_req.we && wb_req.sel[0] && hit[5];
  assign rd       = req && !wb_req.we;
  assign wbyte    = wb_req.dat[7:0];
  assign rx_cfg   = q.regs[S_RX_LOCK_CFG];
  assign freq_err = q.regs[S_CHIP_CFG][B_REF_RATIO] ?
                    freq_err_div16_ppm : freq_err_div64_ppm;    // RULE9
  assign rx_alarm_byte = {6'h00, receive_signal_loss, q.rx_lol};
  assign tx_flag_byte  = {5'h00, q.eye_alarm, run_alarm, q.tx_los};

  always_comb begin
    d = q;
    d.ack = req;
    // ignoring sel on reads: every register is one byte wide
    if (wr) begin
      d.regs[hit[4:0]] = wbyte;
    end
    if (wr && (idx == OFS_JT_INDEX) && wbyte[B_JT_COMMIT] &&
        (wbyte[6:0] == JT_ADDR)) begin
      d.jt_thresh = {q.regs[S_JT_DATA2], q.regs[S_JT_DATA1],
                     q.regs[S_JT_DATA0]};                     // RULE6
    end
    if (rd) begin
      case (idx)
        OFS_RX_IRQ:      d.rdata = {7'h00, q.rx_irq};
        OFS_RX_ALARM:    d.rdata = rx_alarm_byte;             // RULE14
        OFS_TX_IRQ:      d.rdata = {7'h00, q.tx_irq};
        OFS_TX_LOS_FLAG: d.rdata = tx_flag_byte;              // RULE18
        OFS_EYE_VALUE:   d.rdata = tx_eye_measure;            // RULE20
        OFS_ACQ_LOOP:    d.rdata = BYTE_RESET;
        default:         d.rdata = hit[5] ? q.regs[hit[4:0]] : BYTE_RESET;
      endcase
    end

    // first stage feeds only the second
    d.td_sync = {q.td_sync[1:0], transmit_data_input};
    if (q.td_sync[1] == q.td_sync[2]) begin
      d.td_bit = q.td_sync[2];
    end

    if (jitter_measure > q.jt_thresh) begin
      d.jit_lol = 1'b1;                                       // RULE4
    end else if (jitter_measure < q.jt_thresh) begin
      d.jit_lol = 1'b0;                                       // RULE4
    end
    // between the two limits the flag keeps its state
    if (freq_err > FREQ_SET_PPM) begin
      d.freq_lol = 1'b1;                                      // RULE8
    end else if (freq_err <= FREQ_CLR_PPM) begin
      d.freq_lol = 1'b0;                                      // RULE25
    end
    d.rx_lol = (jitter_mode(rx_cfg) ? q.jit_lol : q.freq_lol) ||  // RULE1 RULE2 RULE3
               (rx_cfg[B_LOL_ON_LOS] && receive_signal_loss);     // RULE15 RULE24
    d.acq_search = q.rx_lol;                                  // RULE5
    d.rx_squelch = q.rx_lol && q.regs[S_RX_PATH_CFG][B_SQ_ON_LOL];  // RULE16
    d.rx_ltr     = rx_cfg[B_FORCE_LTR] ||
                   (rx_cfg[B_LTR_ON_LOS] && receive_signal_loss);   // RULE17 RULE23

    if (!q.regs[S_EYE_CFG][B_EYE_EN]) begin
      d.eye_alarm = 1'b0;
    end else if (tx_eye_measure < q.regs[S_EYE_THRESH]) begin
      d.eye_alarm = 1'b1;                                     // RULE20
    end else if (tx_eye_measure > q.regs[S_EYE_RELEASE]) begin
      d.eye_alarm = 1'b0;                                     // RULE20
    end
    d.tx_los = (q.regs[S_TX_LOS_CTRL][B_RUN_EN] && run_alarm) ||
               (q.regs[S_TX_LOS_CTRL][B_EYE_SEL] && q.eye_alarm);   // RULE18
    // squelch wins when both actions are configured
    d.tx_squelch = q.tx_los && q.regs[S_TX_PATH_CFG][B_TX_SQUELCH];  // RULE21
    d.tx_clkpat  = q.tx_los && !q.regs[S_TX_PATH_CFG][B_TX_SQUELCH] &&
                   q.regs[S_TX_PATH_CFG][B_TX_CLKPAT];              // RULE21
    d.tx_ltr     = q.tx_los && q.regs[S_TX_LOCK_CFG][B_LTR_ON_LOS];  // RULE22
    d.tx_ref_cal = !q.regs[S_TX_CAL_CFG][B_CAL_MODE];                // RULE22

    // sticky flags clear on read; a new rise in that cycle still sets
    d.rx_irq = (d.rx_lol && !q.rx_lol) ||
               (q.rx_irq && !(rd && idx == OFS_RX_IRQ));      // RULE14 RULE26
    d.tx_irq = (d.tx_los && !q.tx_los) ||
               (q.tx_irq && !(rd && idx == OFS_TX_IRQ));      // RULE26
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_q            = q.ack;
  assign wb_dat_q            = {24'h000000, q.rdata};
  assign receive_lock_lost_q = q.rx_lol;
  assign rx_acq_search_q     = q.acq_search;
  assign rx_data_squelch_q   = q.rx_squelch;
  assign rx_cmu_ref_lock_q   = q.rx_ltr;
  assign tx_signal_loss_q    = q.tx_los;
  assign tx_data_squelch_q   = q.tx_squelch;
  assign tx_clock_pattern_q  = q.tx_clkpat;
  assign tx_lock_to_ref_q    = q.tx_ltr;
  assign tx_ref_cal_q        = q.tx_ref_cal;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_eye_low;
    q.regs[S_EYE_CFG][B_EYE_EN] && q.regs[S_TX_LOS_CTRL][B_EYE_SEL] &&
    (tx_eye_measure < q.regs[S_EYE_THRESH]);
  endsequence

  sequence s_eye_held;
    q.regs[S_EYE_CFG][B_EYE_EN] && q.regs[S_TX_LOS_CTRL][B_EYE_SEL];
  endsequence

  a_wb_ack_once: assert property (req |=> q.ack ##1 !q.ack)
    else $error("ack not a single cycle");
  a_jit_lol_set: assert property (                             // RULE4
    jitter_mode(rx_cfg) && $stable(rx_cfg) && jitter_measure > q.jt_thresh
    |=> ##1 q.rx_lol)
    else $error("jitter over threshold not flagged");
  a_freq_lol_set: assert property (                            // RULE8
    !jitter_mode(rx_cfg) && $stable(rx_cfg) && freq_err > FREQ_SET_PPM
    |=> ##1 q.rx_lol)
    else $error("frequency error over limit not flagged");
  a_freq_hold: assert property (                               // RULE25
    freq_err > FREQ_CLR_PPM && freq_err <= FREQ_SET_PPM
    |=> q.freq_lol == $past(q.freq_lol))
    else $error("frequency flag moved inside hysteresis");
  a_los_to_lol: assert property (                              // RULE15
    rx_cfg[B_LOL_ON_LOS] && receive_signal_loss |=> q.rx_lol)
    else $error("signal loss did not set lock lost");
  a_acq_follow: assert property (q.rx_lol |=> q.acq_search)    // RULE5
    else $error("acquisition search not restarted");
  a_rx_squelch: assert property (                              // RULE16
    q.rx_lol && q.regs[S_RX_PATH_CFG][B_SQ_ON_LOL] |=> q.rx_squelch)
    else $error("receive data not squelched");
  a_rx_ref_lock: assert property (                             // RULE17
    rx_cfg[B_FORCE_LTR] |=> q.rx_ltr)
    else $error("forced reference lock missing");
  a_eye_to_los: assert property (                              // RULE18
    s_eye_low ##1 s_eye_held |=> q.tx_los)
    else $error("eye alarm did not raise transmit loss");
  a_tx_squelch: assert property (                              // RULE21
    q.tx_los && q.regs[S_TX_PATH_CFG][B_TX_SQUELCH]
    |=> q.tx_squelch && !q.tx_clkpat)
    else $error("transmit squelch wrong");
  a_irq_sticky: assert property (                              // RULE26
    q.rx_irq && !(rd && idx == OFS_RX_IRQ) |=> q.rx_irq)
    else $error("receive interrupt flag lost");
  a_thresh_load: assert property (                             // RULE6
    wr && idx == OFS_JT_INDEX && wbyte == {1'b1, JT_ADDR}
    |=> q.jt_thresh == {q.regs[S_JT_DATA2], q.regs[S_JT_DATA1],
                        q.regs[S_JT_DATA0]})
    else $error("threshold commit not applied");

endmodule : lsm_monitor

/* File: lsm_host_model.sv */
/*
  Host model: classic Wishbone master plus the host's register duties.
  Assumes the monitor acks each request; waits end only by bench timeout.
*/
module lsm_host_model (
  input  wire logic        clock,
  output lsm_pkg::lsm_wb_req_t wb_req,
  input  wire logic        wb_ack_q,
  input  wire logic [31:0] wb_dat_q
);
  import lsm_pkg::*;
  initial wb_req = '0;
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    wb_req <= '{1'b1, 1'b1, w, {2'b00, idx, 2'b00}, 4'h1, {24'h0, d}};
    do @(posedge clock); while (wb_ack_q !== 1'b1);
    q = wb_dat_q[7:0];
    wb_req <= '0;
    // idle cycle so the next request is a fresh one
    @(posedge clock);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    xfer(1'b0, idx, 8'h00, q);
  endtask : rd
  task automatic load_thresh();
    wr(OFS_JT_DATA0, 8'ha0);
    wr(OFS_JT_DATA1, 8'h3f);
    wr(OFS_JT_DATA2, 8'hb9);
    wr(OFS_JT_INDEX, 8'h04);
    wr(OFS_JT_INDEX, 8'h84);
  endtask : load_thresh
  task automatic start_up();
    wr(OFS_DET_GAIN, 8'h0d);
    wr(OFS_TUNE_A, 8'h38);
    wr(OFS_TUNE_B, 8'h41);
    wr(OFS_TUNE_C, 8'h03);
  endtask : start_up
  // always written here; skipping is only allowed with reference cal
  task automatic track_lock(input logic lost);
    wr(OFS_ACQ_LOOP, lost ? 8'h98 : 8'h00);
  endtask : track_lock
endmodule : lsm_host_model

/* File: test_lsm_monitor.sv */
/*
  Self-checking bench for the lock and signal alarm monitor.
  Assumes the host model drives the register bus.
*/
module test_lsm_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  import lsm_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  lsm_wb_req_t wb_req;
  logic        wb_ack_q;
  logic [31:0] wb_dat_q;
  logic [23:0] jit = 24'h0;
  logic [15:0] f64 = 16'h0;
  logic [15:0] f16 = 16'h0;
  logic        los = 1'b0;
  logic        tdi = 1'b0;
  logic        tog = 1'b1;
  logic [7:0]  eye = 8'hff;
  logic        lol, srch, rsq, rref, tlos, tsq, tclk, tltr, tcal;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [7:0]  ri [4] = '{OFS_DET_GAIN, OFS_TUNE_A, OFS_TUNE_B, OFS_TUNE_C};
  logic [7:0]  rv [4] = '{8'h0d, 8'h38, 8'h41, 8'h03};
  logic [7:0]  mc [4] = '{8'h00, 8'h02, 8'h08, 8'h0c};
  logic        fm [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  always #50 clock = ~clock;
  // two-cycle hold: a pin toggling every clock never passes the agreement filter
  always begin
    repeat (2) @(posedge clock);
    if (tog) tdi <= ~tdi;
  end
  lsm_host_model host (.clock(clock), .wb_req(wb_req), .wb_ack_q(wb_ack_q),
                       .wb_dat_q(wb_dat_q));
  lsm_monitor dut (.clock(clock), .reset_n(reset_n), .wb_req(wb_req),
    .wb_ack_q(wb_ack_q), .wb_dat_q(wb_dat_q), .jitter_measure(jit),
    .freq_err_div64_ppm(f64), .freq_err_div16_ppm(f16),
    .receive_signal_loss(los), .transmit_data_input(tdi), .tx_eye_measure(eye),
    .receive_lock_lost_q(lol), .rx_acq_search_q(srch), .rx_data_squelch_q(rsq),
    .rx_cmu_ref_lock_q(rref), .tx_signal_loss_q(tlos), .tx_data_squelch_q(tsq),
    .tx_clock_pattern_q(tclk), .tx_lock_to_ref_q(tltr), .tx_ref_cal_q(tcal));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    host.rd(idx, q);
    chk($sformatf("reg %h", idx), q, exp);
  endtask : rdc
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    settle(5000);
    err_total++;
    wrap_up();
  end
  initial begin
    settle(2);
    reset_n <= 1'b1;
    settle(6);
    chk("lol", 8'(lol), 8'h00);
    chk("refcal", 8'(tcal), 8'h01);
    rdc(OFS_RX_LOCK_CFG, 8'h00);
    rdc(OFS_TX_LOS_CTRL, 8'h00);
    host.start_up();
    for (int i = 0; i < 4; i++) rdc(ri[i], rv[i]);
    host.wr(8'h30, 8'h5a);
    rdc(8'h30, 8'h00);
    host.wr(OFS_RX_ALARM, 8'hff);
    rdc(OFS_RX_ALARM, 8'h00);
    // default threshold catches this measure; the loaded one does not
    jit <= 24'h900000;
    settle(5);
    chk("lol", 8'(lol), 8'h01);
    chk("search", 8'(srch), 8'h01);
    host.track_lock(1'b1);
    rdc(OFS_ACQ_LOOP, 8'h00);
    rdc(OFS_RX_ALARM, 8'h01);
    jit <= 24'h0;
    settle(5);
    chk("lol", 8'(lol), 8'h00);
    rdc(OFS_RX_ALARM, 8'h00);
    host.track_lock(1'b0);
    rdc(OFS_RX_IRQ, 8'h01);
    rdc(OFS_RX_IRQ, 8'h00);
    jit <= 24'h900000;
    host.load_thresh();
    settle(5);
    chk("lol", 8'(lol), 8'h00);
    jit <= 24'hb93fa1;
    settle(5);
    chk("lol", 8'(lol), 8'h01);
    jit <= 24'hb93f9f;
    settle(5);
    chk("lol", 8'(lol), 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(OFS_RX_LOCK_CFG, mc[i]);
      jit <= 24'hf00000;
      settle(5);
      chk("mode jit", 8'(lol), 8'(!fm[i]));
      chk("ltr", 8'(rref), 8'(mc[i][1]));
      jit <= 24'h0;
      f64 <= 16'd1001;
      settle(5);
      chk("mode freq", 8'(lol), 8'(fm[i]));
      f64 <= 16'd500;
      settle(5);
      chk("hold", 8'(lol), 8'(fm[i]));
      f64 <= 16'd200;
      settle(5);
      chk("clr", 8'(lol), 8'h00);
    end
    // ratio and limit checks only mean something with the frequency detector
    host.wr(OFS_RX_LOCK_CFG, 8'h08);
    f64 <= 16'd1000;
    settle(5);
    chk("edge", 8'(lol), 8'h00);
    f64 <= 16'd0;
    f16 <= 16'd2000;
    settle(5);
    chk("div64", 8'(lol), 8'h00);
    host.wr(OFS_CHIP_CFG, 8'h01);
    settle(5);
    chk("div16", 8'(lol), 8'h01);
    f16 <= 16'd0;
    host.wr(OFS_RX_LOCK_CFG, 8'h60);
    host.wr(OFS_RX_PATH_CFG, 8'h01);
    los <= 1'b1;
    settle(5);
    chk("lol los", 8'(lol), 8'h01);
    chk("ltr los", 8'(rref), 8'h01);
    chk("rx sq", 8'(rsq), 8'h01);
    rdc(OFS_RX_ALARM, 8'h03);
    los <= 1'b0;
    settle(5);
    chk("rx sq", 8'(rsq), 8'h00);
    host.wr(OFS_RUN_ASSERT, 8'h05);
    host.wr(OFS_RUN_CLEAR, 8'h03);
    host.wr(OFS_TX_PATH_CFG, 8'h01);
    host.wr(OFS_TX_LOS_CTRL, 8'h01);
    tog <= 1'b0;
    settle(4);
    chk("run early", 8'(tlos), 8'h00);
    settle(16);
    chk("run", 8'(tlos), 8'h01);
    chk("tx sq", 8'(tsq), 8'h01);
    rdc(OFS_TX_LOS_FLAG, 8'h03);
    rdc(OFS_TX_IRQ, 8'h01);
    tog <= 1'b1;
    settle(20);
    chk("run clr", 8'(tlos), 8'h00);
    eye <= 8'h30;
    settle(5);
    chk("eye off", 8'(tlos), 8'h00);
    host.wr(OFS_EYE_THRESH, 8'h40);
    host.wr(OFS_EYE_RELEASE, 8'h60);
    host.wr(OFS_EYE_CFG, 8'h01);
    host.wr(OFS_TX_PATH_CFG, 8'h02);
    host.wr(OFS_TX_LOCK_CFG, 8'h20);
    host.wr(OFS_TX_LOS_CTRL, 8'h02);
    settle(5);
    chk("eye", 8'(tlos), 8'h01);
    chk("tx clk", 8'(tclk), 8'h01);
    chk("tx ltr", 8'(tltr), 8'h01);
    rdc(OFS_EYE_VALUE, 8'h30);
    rdc(OFS_TX_LOS_FLAG, 8'h05);
    eye <= 8'h50;
    settle(5);
    chk("eye hold", 8'(tlos), 8'h01);
    eye <= 8'h70;
    settle(5);
    chk("eye clr", 8'(tlos), 8'h00);
    host.wr(OFS_TX_CAL_CFG, 8'h02);
    settle(3);
    chk("refcal", 8'(tcal), 8'h00);
    wrap_up();
  end
endmodule : test_lsm_monitor
